// [logic/irq_persist_pkg.sv]
// Package holding register map, field layout and timing constants for the persistence block.
package irq_persist_pkg;

    // ********************************************************************
    // Register offsets and reset values
    // ********************************************************************
    localparam logic [7:0] interrupt_persistence_addr = 8'h0c;
    localparam logic [7:0] measurement_setup_addr     = 8'h0d;
    localparam logic [7:0] led_pulse_count_addr       = 8'h0e;
    localparam logic [7:0] interrupt_persistence_rst  = 8'h00;
    localparam logic [7:0] measurement_setup_rst      = 8'h00;
    localparam logic [7:0] led_pulse_count_rst        = 8'h00;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int prox_persist_lsb     = 4;
    localparam int light_persist_lsb    = 0;
    localparam int light_gain_scale_pos = 2;
    localparam int wait_long_pos        = 1;
    localparam int drive_reduce_pos     = 0;
    localparam logic [7:0] setup_used_mask = 8'h07;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int wait_step_us   = 2730;
    localparam int clk_period_ns  = 10;
    localparam int wait_step_cyc  = (wait_step_us * 1000) / clk_period_ns;
    localparam int wait_long_mult = 12;
    localparam int light_step_cnt = 5;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        done;
        logic [15:0] value;
    } result_s;

endpackage : irq_persist_pkg

// [logic/persist_filter.sv]
// One persistence filter: counts uninterrupted out-of-window results and raises an interrupt.
module persist_filter #(
    parameter int CNT_W = 6
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Settings
    input  wire logic [CNT_W-1:0]            need,
    input  wire logic                        every_cycle,
    input  wire logic                        irq_mask,
    input  wire logic [15:0]                 thr_low,
    input  wire logic [15:0]                 thr_high,
    // Result stream
    input  wire irq_persist_pkg::result_s    result,
    // Event out
    output logic                             irq_set
);

    logic [CNT_W-1:0] run_r;
    logic             outside;
    logic [CNT_W-1:0] run_nxt;

    assign outside = (result.value < thr_low) || (result.value > thr_high);
    assign run_nxt = outside ? ((run_r == {CNT_W{1'b1}}) ? run_r : run_r + 1'b1) : '0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_r <= '0;
        end else if (result.done) begin
            run_r <= run_nxt;
        end
    end

    // Saturating count means a run longer than the setting keeps interrupting, as a level would.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_set <= 1'b0;
        end else begin
            irq_set <= result.done && irq_mask && (every_cycle || (outside && run_nxt >= need));
        end
    end

endmodule : persist_filter

// [logic/sensor_irq_persistence_config.sv]
// Persistence filtering and measurement setup registers for a light and proximity sensor.
//
// Contract
// - Proximity and light paths filter separately, each with own setting and count.
// - Light interrupt decisions use only the channel-0 result.
// - Proximity field bits 7:4; zero means every proximity cycle interrupts.
// - Proximity field 1..15 needs that many consecutive out-of-window results.
// - Light field bits 3:0; zero means every light cycle interrupts.
// - Light field 1, 2, 3 need 1, 2, 3 consecutive out-of-window results.
// - Light field 4 and up needs five per step, 60 at code 15.
// - Persistence register resets to 0x00.
// - Gain-scale bit scales 1x and 8x light gain by 0.16.
// - Wait-long bit stretches each wait period twelvefold.
// - Drive-reduce bit cuts LED sink current by nine.
// - Pulse count field sets LED pulses per proximity accumulation.
// - Out of window means below low or above high threshold.
// - Interrupt raised only while that path's mask bit is set.
// - Base wait counted in 2.73 ms steps, wait-long multiplies that base.
module sensor_irq_persistence_config #(
    // Clock cycles in one base wait step; it depends on the clock, so it may be shortened.
    parameter int WAIT_STEP_CYC = irq_persist_pkg::wait_step_cyc
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Register access from the command decoder
    input  wire irq_persist_pkg::reg_req_s   reg_req,
    output logic [7:0]                       reg_rdata,
    output logic                             reg_hit,
    // Settings from other registers
    input  wire logic                        prox_irq_mask,
    input  wire logic                        light_irq_mask,
    input  wire logic [15:0]                 light_thr_low,
    input  wire logic [15:0]                 light_thr_high,
    input  wire logic [15:0]                 prox_thr_low,
    input  wire logic [15:0]                 prox_thr_high,
    input  wire logic [1:0]                  light_gain_select,
    // Conversion results
    input  wire irq_persist_pkg::result_s    channel0_result,
    input  wire irq_persist_pkg::result_s    prox_result,
    // Interrupt events toward the status logic
    output logic                             prox_irq_set,
    output logic                             light_irq_set,
    // Controls toward analog and cycle logic
    output logic                             light_gain_scaled,
    output logic                             drive_reduce,
    output logic [7:0]                       led_pulse_count,
    input  wire logic                        wait_start,
    input  wire logic [7:0]                  wait_count,
    output logic                             wait_busy
);

    // ********************************************************************
    // Registers
    // ********************************************************************
    typedef enum logic [1:0] {
        sel_none    = 2'b00,
        sel_persist = 2'b01,
        sel_setup   = 2'b10,
        sel_pulse   = 2'b11
    } reg_sel_e;

    logic [7:0] persist_r;
    logic [7:0] setup_r;
    logic [7:0] pulse_r;
    reg_sel_e   reg_sel;

    // One decode serves the write enables and the read mux, so the two can never disagree.
    function automatic reg_sel_e reg_sel_of(input logic [7:0] addr);
        unique case (addr)
            irq_persist_pkg::interrupt_persistence_addr: reg_sel_of = sel_persist;
            irq_persist_pkg::measurement_setup_addr:     reg_sel_of = sel_setup;
            irq_persist_pkg::led_pulse_count_addr:       reg_sel_of = sel_pulse;
            default:                                     reg_sel_of = sel_none;
        endcase
    endfunction : reg_sel_of

    assign reg_sel = reg_sel_of(reg_req.addr);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            persist_r <= irq_persist_pkg::interrupt_persistence_rst;
        end else if (reg_req.wr && reg_sel == sel_persist) begin
            persist_r <= reg_req.wdata;
        end
    end

    // Reserved bits are not stored, so a careless write cannot change them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_r <= irq_persist_pkg::measurement_setup_rst;
        end else if (reg_req.wr && reg_sel == sel_setup) begin
            setup_r <= reg_req.wdata & irq_persist_pkg::setup_used_mask;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_r <= irq_persist_pkg::led_pulse_count_rst;
        end else if (reg_req.wr && reg_sel == sel_pulse) begin
            pulse_r <= reg_req.wdata;
        end
    end

    always_comb begin
        reg_hit   = 1'b1;
        reg_rdata = 8'h00;
        unique case (reg_sel)
            sel_persist: reg_rdata = persist_r;
            sel_setup:   reg_rdata = setup_r;
            sel_pulse:   reg_rdata = pulse_r;
            sel_none:    reg_hit   = 1'b0;
        endcase
    end

    // ********************************************************************
    // Persistence thresholds
    // ********************************************************************
    logic [3:0] prox_field;
    logic [3:0] light_field;
    logic [5:0] light_need;

    assign prox_field  = persist_r[irq_persist_pkg::prox_persist_lsb +: 4];
    assign light_field = persist_r[irq_persist_pkg::light_persist_lsb +: 4];

    function automatic logic [5:0] light_need_of(input logic [3:0] code);
        if (code < 4'h4) begin
            light_need_of = {2'h0, code};
        end else begin
            light_need_of = 6'(irq_persist_pkg::light_step_cnt * (int'(code) - 3));
        end
    endfunction : light_need_of

    assign light_need = light_need_of(light_field);

    // ********************************************************************
    // Filters, one per path
    // ********************************************************************
    persist_filter #(.CNT_W(6)) prox_filter (
        .clk         (clk),
        .rst_b       (rst_b),
        .need        ({2'h0, prox_field}),
        .every_cycle (prox_field == 4'h0),
        .irq_mask    (prox_irq_mask),
        .thr_low     (prox_thr_low),
        .thr_high    (prox_thr_high),
        .result      (prox_result),
        .irq_set     (prox_irq_set)
    );

    persist_filter #(.CNT_W(6)) light_filter (
        .clk         (clk),
        .rst_b       (rst_b),
        .need        (light_need),
        .every_cycle (light_field == 4'h0),
        .irq_mask    (light_irq_mask),
        .thr_low     (light_thr_low),
        .thr_high    (light_thr_high),
        .result      (channel0_result),
        .irq_set     (light_irq_set)
    );

    // ********************************************************************
    // Analog controls
    // ********************************************************************
    // Scaling applies only to the two lowest gains; higher gains are left alone on purpose.
    assign light_gain_scaled = setup_r[irq_persist_pkg::light_gain_scale_pos] &&
                               (light_gain_select <= 2'h1);
    assign drive_reduce      = setup_r[irq_persist_pkg::drive_reduce_pos];
    assign led_pulse_count   = pulse_r;

    // ********************************************************************
    // Wait timer
    // ********************************************************************
    logic [21:0] tick_r;
    logic [3:0]  mult_r;
    logic [8:0]  steps_r;
    logic        step_end;
    logic        mult_end;
    logic        wait_go;

    assign step_end  = tick_r == 22'(WAIT_STEP_CYC - 1);
    assign mult_end  = !setup_r[irq_persist_pkg::wait_long_pos] ||
                       mult_r == 4'(irq_persist_pkg::wait_long_mult - 1);
    assign wait_busy = steps_r != 9'h000;
    assign wait_go   = wait_start && !wait_busy;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_r <= '0;
        end else if (wait_go) begin
            tick_r <= '0;
        end else if (wait_busy) begin
            tick_r <= step_end ? '0 : tick_r + 1'b1;
        end
    end

    // The wait-long bit is read live, so changing it during a wait alters the steps still to come.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mult_r <= '0;
        end else if (wait_go) begin
            mult_r <= '0;
        end else if (wait_busy && step_end) begin
            mult_r <= mult_end ? '0 : mult_r + 1'b1;
        end
    end

    // Count is two's complement: 0xff waits one step, 0x00 waits 256.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            steps_r <= '0;
        end else if (wait_go) begin
            steps_r <= 9'h100 - {1'b0, wait_count};
        end else if (wait_busy && step_end && mult_end) begin
            steps_r <= steps_r - 1'b1;
        end
    end

endmodule : sensor_irq_persistence_config

// [dv/irq_persist_properties.sv]
// Port checker for the persistence and setup block.
module irq_persist_properties (
    // Clock and reset
    input wire logic                      clk,
    input wire logic                      rst_b,
    // Register access
    input wire irq_persist_pkg::reg_req_s reg_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      reg_hit,
    // Results and events
    input wire logic                      prox_irq_mask,
    input wire logic                      light_irq_mask,
    input wire irq_persist_pkg::result_s  channel0_result,
    input wire irq_persist_pkg::result_s  prox_result,
    input wire logic                      prox_irq_set,
    input wire logic                      light_irq_set,
    // Controls
    input wire logic [1:0]                light_gain_select,
    input wire logic                      light_gain_scaled,
    input wire logic                      drive_reduce,
    input wire logic [7:0]                led_pulse_count,
    input wire logic                      wait_start,
    input wire logic                      wait_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic mapped;
    assign mapped = reg_req.addr inside {8'h0c, 8'h0d, 8'h0e};
    a_unmapped_quiet: assert property (!mapped |-> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped address answered");
    a_setup_reserved: assert property (reg_req.addr == 8'h0d |-> reg_rdata[7:3] == 5'h00)
        else $error("setup reserved bits read nonzero");
    a_pulse_write: assert property (reg_req.wr && reg_req.addr == 8'h0e |=> led_pulse_count == $past(reg_req.wdata))
        else $error("pulse count not written");
    a_drive_write: assert property (reg_req.wr && reg_req.addr == 8'h0d |=> drive_reduce == $past(reg_req.wdata[0]))
        else $error("drive reduce not written");
    a_gain_scale_gate: assert property (light_gain_scaled |-> light_gain_select <= 2'h1)
        else $error("gain scaling above 8x");
    a_prox_irq_cause: assert property (prox_irq_set |-> $past(prox_result.done) && $past(prox_irq_mask))
        else $error("proximity event without masked-in result");
    a_light_irq_cause: assert property (light_irq_set |-> $past(channel0_result.done && light_irq_mask))
        else $error("light event without masked-in channel0 result");
    a_wait_begin: assert property (wait_start && !wait_busy |=> wait_busy)
        else $error("wait did not start");
    a_wait_hold: assert property ($rose(wait_busy) |-> wait_busy [*8])
        else $error("wait ended early");
    c_prox: cover property (prox_irq_set);
    c_light: cover property (light_irq_set);
    c_wait: cover property ($rose(wait_busy));
endmodule : irq_persist_properties

bind sensor_irq_persistence_config irq_persist_properties chk (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .prox_irq_mask(prox_irq_mask), .light_irq_mask(light_irq_mask),
    .channel0_result(channel0_result), .prox_result(prox_result), .prox_irq_set(prox_irq_set),
    .light_irq_set(light_irq_set), .light_gain_select(light_gain_select), .light_gain_scaled(light_gain_scaled),
    .drive_reduce(drive_reduce), .led_pulse_count(led_pulse_count), .wait_start(wait_start), .wait_busy(wait_busy));

// [dv/result_source.sv]
// Behavioural conversion cycle that hands finished results to the block.
module result_source (
    // Clock
    input wire logic                 clk,
    // Result stream
    output irq_persist_pkg::result_s res
);
    timeunit 1ns;
    timeprecision 100ps;
    initial res = '0;
    // The value is not held after the cycle, so it is inverted rather than left valid.
    task automatic send(input logic [15:0] v);
        res.done = 1'b1;
        res.value = v;
        @(posedge clk);
        #1;
        res.done = 1'b0;
        res.value = ~v;
    endtask : send
endmodule : result_source

// [dv/tb_top.sv]
// Self-checking bench for the persistence filters and setup registers.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                      clk = 1'b0;
    logic                      rst_b = 1'b0;
    irq_persist_pkg::reg_req_s req = '0;
    logic                      pm = 1'b0;
    logic                      lm = 1'b0;
    logic                      ws = 1'b0;
    logic [1:0]                gs = 2'h0;
    irq_persist_pkg::result_s  c0;
    irq_persist_pkg::result_s  px;
    logic [7:0]                rdata;
    logic [7:0]                pcnt;
    logic                      hit, pirq, lirq, gsc, drv, busy;
    int                        n_mismatch = 0;
    int                        checked = 0;
    logic [7:0]                wc = 8'hfe;
    localparam int             wait_step = 8;
    always #5 clk = ~clk;
    result_source light_src (.clk(clk), .res(c0));
    result_source prox_src (.clk(clk), .res(px));
    sensor_irq_persistence_config #(.WAIT_STEP_CYC(wait_step)) uut (.clk(clk), .rst_b(rst_b), .reg_req(req),
        .reg_rdata(rdata), .reg_hit(hit),
        .prox_irq_mask(pm), .light_irq_mask(lm), .light_thr_low(16'h0100), .light_thr_high(16'h0200),
        .prox_thr_low(16'h0100), .prox_thr_high(16'h0200), .light_gain_select(gs), .channel0_result(c0),
        .prox_result(px), .prox_irq_set(pirq), .light_irq_set(lirq), .light_gain_scaled(gsc),
        .drive_reduce(drv), .led_pulse_count(pcnt), .wait_start(ws), .wait_count(wc), .wait_busy(busy));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    // A spare cycle after each write keeps the strobe from being raised again in the same step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step();
        req.wr = 1'b0;
        step();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req.addr = a;
        step();
        chk("rdata", 16'(rdata), 16'(e));
    endtask : rd
    task automatic res(input logic l, input logic [15:0] v, input logic ep, input logic el);
        if (l) light_src.send(v);
        else prox_src.send(v);
        chk("prox_irq", 16'(pirq), 16'(ep));
        chk("light_irq", 16'(lirq), 16'(el));
        step();
    endtask : res
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rd(8'h0c, 8'h00);
        rd(8'h3c, 8'h00);
        chk("hit", 16'(hit), 16'h0000);
        wr(8'h0d, 8'h04);
        chk("scaled", 16'(gsc), 16'h0001);
        wr(8'h0d, 8'h01);
        rd(8'h0d, 8'h01);
        chk("scaled", 16'(gsc), 16'h0000);
        chk("drive", 16'(drv), 16'h0001);
        wr(8'h0e, 8'ha5);
        chk("pulses", 16'(pcnt), 16'h00a5);
        rd(8'h0e, 8'ha5);
    endtask : t_regs
    task automatic t_every();
        wr(8'h0c, 8'h00);
        res(1'b0, 16'h0150, 1'b1, 1'b0);
        res(1'b1, 16'h0150, 1'b0, 1'b1);
    endtask : t_every
    task automatic t_filter(input logic l);
        int need;
        for (int c = 1; c < 16; c++) begin
            need = !l ? c : (c < 4 ? c : 5 * (c - 3));
            wr(8'h0c, l ? 8'(c) : 8'(c << 4));
            repeat (need - 1) res(l, 16'h0201, 1'b0, 1'b0);
            res(l, 16'h0200, 1'b0, 1'b0);
            repeat (need - 1) res(l, 16'h00ff, 1'b0, 1'b0);
            res(l, 16'h0201, !l, l);
            res(l, 16'h0100, 1'b0, 1'b0);
        end
    endtask : t_filter
    task automatic t_mask();
        wr(8'h0c, 8'h11);
        pm = 1'b0;
        lm = 1'b0;
        res(1'b0, 16'h0300, 1'b0, 1'b0);
        res(1'b1, 16'h0300, 1'b0, 1'b0);
        pm = 1'b1;
        res(1'b0, 16'h0300, 1'b1, 1'b0);
    endtask : t_mask
    task automatic t_wait();
        int n;
        for (int lng = 0; lng < 2; lng++) begin
            wr(8'h0d, 8'(lng << irq_persist_pkg::wait_long_pos));
            ws = 1'b1;
            step();
            ws = 1'b0;
            chk("busy", 16'(busy), 16'h0001);
            n = 0;
            while (busy === 1'b1 && n < 400) begin
                // A restart while busy must be refused and leave the length alone.
                ws = (n == 2);
                n++;
                step();
            end
            ws = 1'b0;
            chk("wait_cycles", 16'(n), 16'((256 - wc) * wait_step * (lng ? 12 : 1)));
        end
    endtask : t_wait
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        step();
        t_regs();
        pm = 1'b1;
        lm = 1'b1;
        t_every();
        t_filter(1'b0);
        t_filter(1'b1);
        t_mask();
        t_wait();
        wrap_up();
    end
endmodule : tb_top
